/* File: logic/frt_defines.vh */
`ifndef FRT_DEFINES_VH
`define FRT_DEFINES_VH
// register word byte addresses (wishbone, 32-bit data, one aligned word each)
`define FRT_ADDR_COUNT_LOW 6'h00
`define FRT_ADDR_COUNT_HIGH 6'h04
`define FRT_ADDR_IRQ_STATUS 6'h08
`define FRT_ADDR_IRQ_ENABLE 6'h0C
`define FRT_ADDR_IRQ_CLEAR 6'h10
`define FRT_ADDR_W 6
// count layout
`define FRT_COUNT_W 12
`define FRT_LOW_W 8
`define FRT_HIGH_W 4
`define FRT_COUNT_RESET 12'h000
`define FRT_HELD_RESET 4'h0
// boundary bits for the periodic requests
`define FRT_BIT_128US 7
`define FRT_BIT_1024US 10
// interrupt status layout
`define FRT_IRQ_W 2
`define FRT_IRQ_128US 0
`define FRT_IRQ_1024US 1
`define FRT_IRQ_RESET 2'h0
// timing
`define FRT_TICK_NS 1000
`define FRT_CLK_NS 40
`define FRT_TICK_DIV_W 5
`endif

/* File: logic/frt_tick_gen.v */
`timescale 1ns/10ps
// divides the system clock down to a one-cycle pulse every tick period
module frt_tick_gen #(
    parameter DIV = 25,
    parameter W = 5
) (
    input wire clk_i,
    input wire rst_i,
    output reg tick_o
);
    reg [W-1:0] cnt_q;
    localparam [31:0] LAST_FULL = DIV - 1;
    localparam [W-1:0] LAST = LAST_FULL[W-1:0];
    localparam [W-1:0] ZERO = {W{1'b0}};
    localparam [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_q <= ZERO;
            tick_o <= 1'b0;
        end
        else
        begin
            tick_o <= (cnt_q == LAST);
            if (cnt_q == LAST)
                cnt_q <= ZERO;
            else
                cnt_q <= cnt_q + ONE;
        end
    end
endmodule // frt_tick_gen

/* File: logic/frt_timer.v */
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
`include "frt_defines.vh"
// What this block does
// RL1: twelve-bit count advances by one each microsecond tick, always running.
// RL2: pulse a timer request every 128 microseconds of count.
// RL3: pulse a second timer request every 1.024 milliseconds of count.
// RL4: count wraps from all ones back to zero, spanning about 4 ms.
// RL5: low-byte read returns live bits 7..0 and captures bits 11..8.
// RL6: high read returns the nibble captured at the last low read.
// RL7: high register shows held nibble in bits 3..0, upper bits zero.
// RL8: low register is read-only, zero after reset, writes ignored.
// RL9: requests are one-cycle pulses whenever count bit 7 or bit 10 toggles.
module frt_timer #(
    parameter TICK_DIV = `FRT_TICK_NS / `FRT_CLK_NS,
    parameter TICK_DIV_W = `FRT_TICK_DIV_W
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [`FRT_ADDR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg irq_128us_o,
    output reg irq_1024us_o,
    output reg irq_o
);
    wire tick;
    reg [`FRT_COUNT_W-1:0] count_q;
    reg [`FRT_COUNT_W-1:0] count_d;
    reg [`FRT_HIGH_W-1:0] held_q;
    reg [`FRT_IRQ_W-1:0] status_q;
    reg [`FRT_IRQ_W-1:0] enable_q;
    reg [31:0] rdata;
    reg rd_hit;
    wire req;
    wire rd_strobe;
    wire wr_strobe;
    wire edge_128;
    wire edge_1024;
    wire [`FRT_IRQ_W-1:0] events;
    wire [`FRT_IRQ_W-1:0] clr_bits;
    wire [`FRT_IRQ_W-1:0] status_d;

    frt_tick_gen #(
        .DIV(TICK_DIV),
        .W(TICK_DIV_W)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(tick)
    );

    // free-running count, natural wrap at all ones
    always @*
    begin
        count_d = count_q;
        if (tick)
            count_d = count_q + {{(`FRT_COUNT_W-1){1'b0}}, 1'b1}; // see RL1 // see RL4
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
            count_q <= `FRT_COUNT_RESET;
        else
            count_q <= count_d;
    end

    // boundary crossings: bit 7 toggles every 128 counts, bit 10 every 1024;
    // a rising-only detect would halve both request rates
    assign edge_128 = count_d[`FRT_BIT_128US] ^ count_q[`FRT_BIT_128US]; // see RL2 // see RL9
    assign edge_1024 = count_d[`FRT_BIT_1024US] ^ count_q[`FRT_BIT_1024US]; // see RL3 // see RL9

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_128us_o <= 1'b0;
            irq_1024us_o <= 1'b0;
        end
        else
        begin
            irq_128us_o <= edge_128; // see RL9
            irq_1024us_o <= edge_1024; // see RL9
        end
    end

    // wishbone classic slave, one wait state, ack dropped after one cycle
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign rd_strobe = req & ~wb_we_i;
    assign wr_strobe = req & wb_we_i;

    // capture at the access itself so a later high read sees the same snapshot
    always @(posedge clk_i)
    begin
        if (rst_i)
            held_q <= `FRT_HELD_RESET;
        else if (rd_strobe && wb_adr_i == `FRT_ADDR_COUNT_LOW)
            held_q <= count_q[`FRT_COUNT_W-1:`FRT_LOW_W]; // see RL5
    end

    assign events = {edge_1024, edge_128};
    assign clr_bits = (wr_strobe && wb_adr_i == `FRT_ADDR_IRQ_CLEAR && wb_sel_i[0]) ?
                      wb_dat_i[`FRT_IRQ_W-1:0] : `FRT_IRQ_RESET;
    // a new event in the clearing cycle survives the clear
    assign status_d = (status_q & ~clr_bits) | events;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            status_q <= `FRT_IRQ_RESET;
            enable_q <= `FRT_IRQ_RESET;
            irq_o <= 1'b0;
        end
        else
        begin
            status_q <= status_d;
            if (wr_strobe && wb_adr_i == `FRT_ADDR_IRQ_ENABLE && wb_sel_i[0])
                enable_q <= wb_dat_i[`FRT_IRQ_W-1:0];
            irq_o <= |(status_d & enable_q);
        end
    end

    // read mux; count registers are read-only, writes to them are dropped
    always @*
    begin
        rdata = 32'h00000000;
        rd_hit = 1'b1;
        case (wb_adr_i)
            `FRT_ADDR_COUNT_LOW: rdata[`FRT_LOW_W-1:0] = count_q[`FRT_LOW_W-1:0]; // see RL5 // see RL8
            `FRT_ADDR_COUNT_HIGH: rdata[`FRT_HIGH_W-1:0] = held_q; // see RL6 // see RL7
            `FRT_ADDR_IRQ_STATUS: rdata[`FRT_IRQ_W-1:0] = status_q;
            `FRT_ADDR_IRQ_ENABLE: rdata[`FRT_IRQ_W-1:0] = enable_q;
            `FRT_ADDR_IRQ_CLEAR: rdata = 32'h00000000;
            default: rd_hit = 1'b0;
        endcase
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= req;
            if (rd_strobe && rd_hit)
                wb_dat_o <= rdata;
            else
                wb_dat_o <= 32'h00000000;
        end
    end
endmodule // frt_timer

/* File: tb/frt_timer_chk.sv */
`timescale 1ns/10ps
module frt_timer_chk (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [5:0] wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire irq_128us_o,
    input wire irq_1024us_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire rd = wb_ack_o && !wb_we_i;
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack1: assert property (p_ack1) else $error("ack too long");
    property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("data outside ack");
    property p_hi; rd && wb_adr_i == 6'h04 |-> wb_dat_o[31:4] == 28'h0; endproperty
    a_hi: assert property (p_hi) else $error("high upper bits"); // reserved zero
    property p_lo; rd && wb_adr_i == 6'h00 |-> wb_dat_o[31:8] == 24'h0; endproperty
    a_lo: assert property (p_lo) else $error("low upper bits"); // byte wide
    property p_clr; rd && wb_adr_i == 6'h10 |-> wb_dat_o == 32'h0; endproperty
    a_clr: assert property (p_clr) else $error("clear reads nonzero");
    property p_s1; irq_128us_o |=> !irq_128us_o [*8]; endproperty
    a_s1: assert property (p_s1) else $error("short pulse long"); // one cycle
    property p_s2; irq_1024us_o |=> !irq_1024us_o; endproperty
    a_s2: assert property (p_s2) else $error("long pulse long"); // one cycle
endmodule // frt_timer_chk
bind frt_timer frt_timer_chk chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_o, .wb_ack_o, .irq_128us_o, .irq_1024us_o);

/* File: tb/frt_timer_tb.sv */
`timescale 1ns/10ps
module frt_timer_tb;
    localparam DIV = 2;
    reg clk_i = 0, rst_i = 1, cyc = 0, we = 0;
    reg [5:0] adr = 6'h00;
    reg [31:0] wd = 32'h0, rd, h;
    wire [31:0] dat;
    wire ack, p1, p2, irq;
    integer n_mismatch = 0, n_tests = 0, i;
    time tm;
    frt_timer #(.TICK_DIV(DIV)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(dat), .wb_ack_o(ack),
        .irq_128us_o(p1), .irq_1024us_o(p2), .irq_o(irq));
    initial forever #20 clk_i = ~clk_i;
    task wb(input w, input [5:0] a, input [31:0] d);
        begin
            @(posedge clk_i);
            cyc <= 1;
            we <= w;
            adr <= a;
            wd <= d;
            @(posedge clk_i);
            while (ack !== 1'b1)
                @(posedge clk_i);
            rd = dat;
            cyc <= 0;
        end
    endtask
    task cmp(input string s, input [31:0] e, input [31:0] g);
        begin
            n_tests = n_tests + 1;
            if (g !== e)
            begin
                n_mismatch = n_mismatch + 1;
                $display("wrong value %s: expected %h seen %h", s, e, g);
            end
        end
    endtask
    task wp(input k);
        begin
            @(posedge clk_i);
            while ((k ? p2 : p1) !== 1'b1)
                @(posedge clk_i);
        end
    endtask
    task finish_test;
        begin
            $display("tests %0d mismatches %0d", n_tests, n_mismatch);
            if (n_mismatch == 0 && n_tests > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial
    begin
        #1600000;
        n_mismatch = n_mismatch + 1;
        finish_test;
    end
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        wb(1, 6'h00, 32'hFF);
        wb(0, 6'h00, 0);
        cmp("low", 0, rd & 32'hFFFFFFF0); // near zero, write lost
        wb(0, 6'h04, 0);
        cmp("high", 0, rd); // cleared
        $display("reset test done");
        wp(0);
        tm = $time;
        wp(0);
        cmp("gap128", 128 * DIV * 40, 32'($time - tm)); // spacing
        wp(1);
        tm = $time;
        wp(1);
        cmp("gap1024", 1024 * DIV * 40, 32'($time - tm)); // spacing
        wb(0, 6'h08, 0);
        cmp("status1024", 2, rd & 2); // event seen
        $display("period test done");
        repeat (128 * DIV) @(posedge clk_i);
        wb(0, 6'h00, 0);
        wb(0, 6'h04, 0);
        h = rd;
        for (i = 0; i < 4; i = i + 1)
        begin
            repeat (1024 * DIV) @(posedge clk_i);
            wb(0, 6'h04, 0);
            cmp("held", h, rd); // stale nibble
            wb(0, 6'h00, 0);
            wb(0, 6'h04, 0);
            h = (h + 4) & 32'hF;
            cmp("next", h, rd); // capture and wrap
        end
        $display("capture test done");
        wb(1, 6'h0C, 0);
        wb(1, 6'h10, 3);
        wp(0);
        repeat (2) @(posedge clk_i);
        cmp("masked", 0, 32'(irq));
        wb(0, 6'h08, 0);
        cmp("status", 1, rd & 1); // event seen
        wb(1, 6'h0C, 1);
        repeat (2) @(posedge clk_i);
        cmp("irq", 1, 32'(irq));
        wb(0, 6'h0C, 0);
        cmp("enable", 1, rd);
        wb(1, 6'h10, 1);
        repeat (2) @(posedge clk_i);
        cmp("cleared", 0, 32'(irq));
        wb(0, 6'h14, 0);
        cmp("unmapped", 0, rd);
        $display("irq test done");
        finish_test;
    end
endmodule // frt_timer_tb
